//--- umd_map.svh
// Register map, field positions, reset values and timing counts
`ifndef UMD_MAP_SVH
`define UMD_MAP_SVH

// =============================================================
// Register indices (byte address = 4 * index, channel at bit 5)
`define UMD_REG_DATA 3'h0
`define UMD_REG_MODEM_CTRL 3'h1
`define UMD_REG_LINE_CTRL 3'h2
`define UMD_REG_FEATURE 3'h3
`define UMD_REG_IRQ_EN 3'h4
`define UMD_REG_STATUS 3'h5
`define UMD_REG_MODEM_STATUS 3'h6
`define UMD_REG_DIVISOR 3'h7
`define UMD_CH_LSB 5

// =============================================================
// Field positions
`define UMD_MC_DTR 0
`define UMD_MC_RTS 1
`define UMD_MC_OUT2 3
`define UMD_MC_IRMODE 6
`define UMD_LC_STOP2 2
`define UMD_LC_PAR_EN 3
`define UMD_LC_PAR_EVEN 4
`define UMD_FE_AUTO_RTS 6
`define UMD_FE_AUTO_CTS 7
`define UMD_IE_RX 0
`define UMD_IE_TX 1
`define UMD_IE_CTS 7
`define UMD_ST_RX_VALID 0
`define UMD_ST_OVERRUN 1
`define UMD_ST_PAR_ERR 2
`define UMD_ST_FRAME_ERR 3
`define UMD_ST_TX_READY 5
`define UMD_ST_TX_IDLE 6
`define UMD_MS_CTS 4
`define UMD_MS_DSR 5
`define UMD_MS_RI 6
`define UMD_MS_CD 7

// =============================================================
// Reset values
`define UMD_MC_RESET 8'h00
`define UMD_LC_RESET 8'h00
`define UMD_FE_RESET 8'h00
`define UMD_IE_RESET 8'h00
`define UMD_DIV_RESET 16'h0036

// =============================================================
// Timing
`define UMD_CLK_NS 10
`define UMD_RESET_MIN_NS 40
`define UMD_RESET_MIN_CYC \
  ((`UMD_RESET_MIN_NS + `UMD_CLK_NS - 1) / `UMD_CLK_NS)
`define UMD_OVS_LAST 4'hF
`define UMD_OVS_MID 4'h7

`endif

//--- umd_pkg.sv
// Types shared by the serial channel logic
package umd_pkg;
  typedef enum logic [4:0] {
    UMD_TX_IDLE  = 5'b00001,
    UMD_TX_START = 5'b00010,
    UMD_TX_DATA  = 5'b00100,
    UMD_TX_PAR   = 5'b01000,
    UMD_TX_STOP  = 5'b10000
  } umd_tx_state_t;
  typedef enum logic [4:0] {
    UMD_RX_IDLE  = 5'b00001,
    UMD_RX_START = 5'b00010,
    UMD_RX_DATA  = 5'b00100,
    UMD_RX_PAR   = 5'b01000,
    UMD_RX_STOP  = 5'b10000
  } umd_rx_state_t;
endpackage

//--- umd_sync2.sv
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/100ps
module umd_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- umd_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module umd_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] d1;
  logic v1;
  logic push;
  logic pop;

  assign in_ready = ~v1;
  assign push = in_valid & ~v1;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_data <= '0;
      out_valid <= 1'b0;
      d1 <= '0;
      v1 <= 1'b0;
    end else if (pop) begin
      out_data <= v1 ? d1 : in_data;
      out_valid <= v1 | push;
      v1 <= 1'b0;
    end else if (push) begin
      if (!out_valid) begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end else begin
        d1 <= in_data;
        v1 <= 1'b1;
      end
    end
  end
endmodule

//--- umd_top.sv
// Multi-channel serial transceiver with modem pins and APB registers
`timescale 1ns/100ps
`include "umd_map.svh"

// What this block does
// - Request-to-send output driven low from modem control bit 1.
// - Clear-to-send input readable; pauses transmit under auto flow bit 7.
// - Terminal-ready output low level set by software.
// - Set-ready, carrier and ring inputs are read-only, no other effect.
// - Modem bit 3 set drives irq pin and pulls user output low.
// - Reset held at least 40 ns returns all registers and outputs.
// - During reset transmit line stays high and receive line ignored.
// - Each byte framed with start bit, data bits and stop bits.
// - Optional parity bit sent, checked on receive, mismatch flagged.
// - Receiver locks to each start bit and rebuilds parallel bytes.
// - Timing clock from oscillator input, buffered copy driven out.
// - Standard mode transmit line idles high, also during reset.
module umd_top
  import umd_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  output logic osc_out,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] serial_tx_out,
  input wire logic [NUM_CH-1:0] serial_rx_in,
  output logic [NUM_CH-1:0] request_to_send_out_n,
  input wire logic [NUM_CH-1:0] clear_to_send_in_n,
  output logic [NUM_CH-1:0] terminal_ready_out_n,
  input wire logic [NUM_CH-1:0] set_ready_in_n,
  input wire logic [NUM_CH-1:0] carrier_detect_in_n,
  input wire logic [NUM_CH-1:0] ring_indicator_in_n,
  output logic [NUM_CH-1:0] user_output_two_n,
  output logic [NUM_CH-1:0] channel_irq_out,
  output logic [NUM_CH-1:0] channel_irq_oe
);
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int RESET_MIN_CYC = `UMD_RESET_MIN_CYC;

  // ===========================================================
  // Clock buffer
  assign osc_out = clk_sys;

  // ===========================================================
  // APB decode
  logic addr_ok;
  logic [2:0] reg_idx;
  logic [CH_W-1:0] ch_sel;
  logic setup_ph;
  logic wr_done;
  logic rd_done;
  logic data_wr_req;
  logic rd_took;
  logic [NUM_CH-1:0] tx_in_ready;
  logic [NUM_CH-1:0] rx_head_valid;
  logic [31:0] ch_rd [NUM_CH];

  assign reg_idx = paddr[4:2];
  assign ch_sel = paddr[`UMD_CH_LSB +: CH_W];
  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   (32'(paddr[7:`UMD_CH_LSB]) < NUM_CH);
  assign setup_ph = psel & ~penable;
  assign data_wr_req = psel & penable & pwrite & addr_ok &
                       (reg_idx == `UMD_REG_DATA);
  // Writes to a full transmit buffer wait here
  assign pready = penable & ~(data_wr_req & ~tx_in_ready[ch_sel]);
  assign wr_done = psel & penable & pready & pwrite;
  assign rd_done = psel & penable & pready & ~pwrite;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      rd_took <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= ~addr_ok;
      if (addr_ok && !pwrite) begin
        prdata <= ch_rd[ch_sel];
        rd_took <= rx_head_valid[ch_sel];
      end else begin
        prdata <= 32'h0000_0000;
        rd_took <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Channels
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic sel;
      logic [7:0] modem_control;
      logic [7:0] line_ctrl;
      logic [7:0] enhanced_feature_control;
      logic [7:0] irq_enable;
      logic [15:0] divisor;
      logic [15:0] div_cnt;
      logic tick;
      logic rxd;
      logic cts_n;
      logic dsr_n;
      logic cd_n;
      logic ri_n;
      logic cts_block;
      logic flag_over;
      logic flag_par;
      logic flag_frame;
      logic set_over;
      logic set_par;
      logic set_frame;
      logic [7:0] clr;
      logic txb_valid;
      logic txb_pop;
      logic [DATA_W-1:0] txb_data;
      logic rxb_push;
      logic rxb_ready;
      logic rxb_valid;
      logic rxb_pop;
      logic [DATA_W-1:0] rxb_data;
      logic [DATA_W-1:0] rx_word;
      umd_tx_state_t tx_st;
      umd_rx_state_t rx_st;
      logic [3:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [DATA_W-1:0] tx_shift;
      logic tx_par;
      logic [3:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [DATA_W-1:0] rx_shift;
      logic rx_par;

      assign sel = addr_ok && (ch_sel == CH_W'(g));
      assign clr = (wr_done && sel && reg_idx == `UMD_REG_STATUS) ?
                   pwdata[7:0] : 8'h00;

      // Inputs through two flip-flops; idle and deasserted at reset
      umd_sync2 #(.W(5), .RST_VAL(5'h1F)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d({serial_rx_in[g], clear_to_send_in_n[g], set_ready_in_n[g],
            carrier_detect_in_n[g], ring_indicator_in_n[g]}),
        .q({rxd, cts_n, dsr_n, cd_n, ri_n})
      );

      // =======================================================
      // Registers
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          modem_control <= `UMD_MC_RESET;
          line_ctrl <= `UMD_LC_RESET;
          enhanced_feature_control <= `UMD_FE_RESET;
          irq_enable <= `UMD_IE_RESET;
          divisor <= `UMD_DIV_RESET;
        end else if (wr_done && sel) begin
          if (reg_idx == `UMD_REG_MODEM_CTRL) begin
            modem_control <= pwdata[7:0];
          end else if (reg_idx == `UMD_REG_LINE_CTRL) begin
            line_ctrl <= pwdata[7:0];
          end else if (reg_idx == `UMD_REG_FEATURE) begin
            enhanced_feature_control <= pwdata[7:0];
          end else if (reg_idx == `UMD_REG_IRQ_EN) begin
            irq_enable <= pwdata[7:0];
          end else if (reg_idx == `UMD_REG_DIVISOR) begin
            divisor <= pwdata[15:0];
          end
        end
      end

      // Sticky error flags; a new event wins over a clear
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          flag_over <= 1'b0;
          flag_par <= 1'b0;
          flag_frame <= 1'b0;
        end else begin
          flag_over <= set_over | (flag_over & ~clr[`UMD_ST_OVERRUN]);
          flag_par <= set_par | (flag_par & ~clr[`UMD_ST_PAR_ERR]);
          flag_frame <= set_frame |
                        (flag_frame & ~clr[`UMD_ST_FRAME_ERR]);
        end
      end

      // Read view; set-ready, carrier and ring inputs are only observed here
      always_comb begin
        ch_rd[g] = 32'h0000_0000;
        if (reg_idx == `UMD_REG_DATA) begin
          ch_rd[g][DATA_W-1:0] = rxb_data;
        end else if (reg_idx == `UMD_REG_MODEM_CTRL) begin
          ch_rd[g][7:0] = modem_control;
        end else if (reg_idx == `UMD_REG_LINE_CTRL) begin
          ch_rd[g][7:0] = line_ctrl;
        end else if (reg_idx == `UMD_REG_FEATURE) begin
          ch_rd[g][7:0] = enhanced_feature_control;
        end else if (reg_idx == `UMD_REG_IRQ_EN) begin
          ch_rd[g][7:0] = irq_enable;
        end else if (reg_idx == `UMD_REG_STATUS) begin
          ch_rd[g][`UMD_ST_RX_VALID] = rxb_valid;
          ch_rd[g][`UMD_ST_OVERRUN] = flag_over;
          ch_rd[g][`UMD_ST_PAR_ERR] = flag_par;
          ch_rd[g][`UMD_ST_FRAME_ERR] = flag_frame;
          ch_rd[g][`UMD_ST_TX_READY] = tx_in_ready[g];
          ch_rd[g][`UMD_ST_TX_IDLE] = (tx_st == UMD_TX_IDLE) & ~txb_valid;
        end else if (reg_idx == `UMD_REG_MODEM_STATUS) begin
          ch_rd[g][`UMD_MS_CTS] = ~cts_n;
          ch_rd[g][`UMD_MS_DSR] = ~dsr_n;
          ch_rd[g][`UMD_MS_RI] = ~ri_n;
          ch_rd[g][`UMD_MS_CD] = ~cd_n;
        end else begin
          ch_rd[g][15:0] = divisor;
        end
      end

      // =======================================================
      // Oversampling enable, sixteen per bit
      assign tick = ({1'b0, div_cnt} + 17'h0_0001) >= {1'b0, divisor};
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          div_cnt <= 16'h0000;
        end else begin
          div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
        end
      end

      // =======================================================
      // Transmit path
      umd_buf2 #(.W(DATA_W)) u_txb (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(data_wr_req & sel),
        .in_ready(tx_in_ready[g]),
        .in_data(pwdata[DATA_W-1:0]),
        .out_valid(txb_valid),
        .out_ready(txb_pop),
        .out_data(txb_data)
      );

      assign cts_block = enhanced_feature_control[`UMD_FE_AUTO_CTS] &
                         cts_n;
      assign txb_pop = (tx_st == UMD_TX_IDLE) & txb_valid & ~cts_block;

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          tx_st <= UMD_TX_IDLE;
          tx_cnt <= 4'h0;
          tx_bit <= 3'h0;
          tx_shift <= '0;
          tx_par <= 1'b0;
          serial_tx_out[g] <= 1'b1;
        end else begin
          case (tx_st)
            UMD_TX_IDLE: begin
              serial_tx_out[g] <= 1'b1;
              tx_cnt <= 4'h0;
              if (txb_pop) begin
                tx_shift <= txb_data;
                tx_par <= line_ctrl[`UMD_LC_PAR_EVEN] ? ^txb_data :
                          ~^txb_data;
                serial_tx_out[g] <= 1'b0;
                tx_st <= UMD_TX_START;
              end
            end
            UMD_TX_START: begin
              if (tick) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt == `UMD_OVS_LAST) begin
                  serial_tx_out[g] <= tx_shift[0];
                  tx_bit <= 3'h0;
                  tx_st <= UMD_TX_DATA;
                end
              end
            end
            UMD_TX_DATA: begin
              if (tick) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt == `UMD_OVS_LAST) begin
                  tx_bit <= tx_bit + 3'h1;
                  tx_shift <= tx_shift >> 1;
                  if (tx_bit == 3'(DATA_W - 1)) begin
                    tx_bit <= 3'h0;
                    if (line_ctrl[`UMD_LC_PAR_EN]) begin
                      serial_tx_out[g] <= tx_par;
                      tx_st <= UMD_TX_PAR;
                    end else begin
                      serial_tx_out[g] <= 1'b1;
                      tx_st <= UMD_TX_STOP;
                    end
                  end else begin
                    serial_tx_out[g] <= tx_shift[1];
                  end
                end
              end
            end
            UMD_TX_PAR: begin
              if (tick) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt == `UMD_OVS_LAST) begin
                  serial_tx_out[g] <= 1'b1;
                  tx_st <= UMD_TX_STOP;
                end
              end
            end
            UMD_TX_STOP: begin
              if (tick) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt == `UMD_OVS_LAST) begin
                  tx_bit <= tx_bit + 3'h1;
                  if (tx_bit == {2'b00, line_ctrl[`UMD_LC_STOP2]}) begin
                    tx_st <= UMD_TX_IDLE;
                  end
                end
              end
            end
            default: tx_st <= UMD_TX_IDLE;
          endcase
        end
      end

      // =======================================================
      // Receive path
      assign rx_word = rx_shift;
      assign rxb_pop = rd_done & sel & rd_took &
                       (reg_idx == `UMD_REG_DATA);
      assign rx_head_valid[g] = rxb_valid;

      umd_buf2 #(.W(DATA_W)) u_rxb (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(rxb_push),
        .in_ready(rxb_ready),
        .in_data(rx_word),
        .out_valid(rxb_valid),
        .out_ready(rxb_pop),
        .out_data(rxb_data)
      );

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          rx_st <= UMD_RX_IDLE;
          rx_cnt <= 4'h0;
          rx_bit <= 3'h0;
          rx_shift <= '0;
          rx_par <= 1'b0;
          rxb_push <= 1'b0;
          set_over <= 1'b0;
          set_par <= 1'b0;
          set_frame <= 1'b0;
        end else begin
          rxb_push <= 1'b0;
          set_over <= 1'b0;
          set_par <= 1'b0;
          set_frame <= 1'b0;
          case (rx_st)
            UMD_RX_IDLE: begin
              rx_cnt <= 4'h0;
              if (!rxd) begin
                rx_st <= UMD_RX_START;
              end
            end
            UMD_RX_START: begin
              if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt == `UMD_OVS_MID) begin
                  // Re-check mid start bit to reject glitches
                  rx_cnt <= 4'h0;
                  rx_bit <= 3'h0;
                  rx_par <= line_ctrl[`UMD_LC_PAR_EVEN] ? 1'b0 : 1'b1;
                  rx_st <= rxd ? UMD_RX_IDLE : UMD_RX_DATA;
                end
              end
            end
            UMD_RX_DATA: begin
              if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt == `UMD_OVS_LAST) begin
                  rx_shift <= {rxd, rx_shift[DATA_W-1:1]};
                  rx_par <= rx_par ^ rxd;
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'(DATA_W - 1)) begin
                    rx_st <= line_ctrl[`UMD_LC_PAR_EN] ? UMD_RX_PAR :
                             UMD_RX_STOP;
                  end
                end
              end
            end
            UMD_RX_PAR: begin
              if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt == `UMD_OVS_LAST) begin
                  set_par <= rx_par ^ rxd;
                  rx_st <= UMD_RX_STOP;
                end
              end
            end
            UMD_RX_STOP: begin
              if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt == `UMD_OVS_LAST) begin
                  set_frame <= ~rxd;
                  rxb_push <= rxb_ready;
                  set_over <= ~rxb_ready;
                  rx_st <= UMD_RX_IDLE;
                end
              end
            end
            default: rx_st <= UMD_RX_IDLE;
          endcase
        end
      end

      // =======================================================
      // Modem outputs and interrupt pin
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          request_to_send_out_n[g] <= 1'b1;
          terminal_ready_out_n[g] <= 1'b1;
          user_output_two_n[g] <= 1'b1;
          channel_irq_oe[g] <= 1'b0;
          channel_irq_out[g] <= 1'b0;
        end else begin
          // Auto flow drops the request while receive buffer is full
          request_to_send_out_n[g] <= ~(modem_control[`UMD_MC_RTS] &
            (~enhanced_feature_control[`UMD_FE_AUTO_RTS] |
             rxb_ready));
          terminal_ready_out_n[g] <= ~modem_control[`UMD_MC_DTR];
          user_output_two_n[g] <= ~modem_control[`UMD_MC_OUT2];
          channel_irq_oe[g] <= modem_control[`UMD_MC_OUT2];
          channel_irq_out[g] <= modem_control[`UMD_MC_OUT2] &
            ((irq_enable[`UMD_IE_RX] & rxb_valid) |
             (irq_enable[`UMD_IE_TX] & tx_in_ready[g]) |
             (irq_enable[`UMD_IE_CTS] & cts_block));
        end
      end
    end
  endgenerate
endmodule

//--- umd_checker_assertions.sv
// Port-level assertions for the serial channel block
`timescale 1ns/100ps
module umd_checker #(
  parameter int NUM_CH = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] serial_tx_out,
  input wire logic [NUM_CH-1:0] request_to_send_out_n,
  input wire logic [NUM_CH-1:0] terminal_ready_out_n,
  input wire logic [NUM_CH-1:0] user_output_two_n,
  input wire logic [NUM_CH-1:0] channel_irq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Completed modem control writes, channel 0 and 1
  wire mc0 = psel && penable && pready && pwrite && paddr == 8'h04;
  wire mc1 = psel && penable && pready && pwrite && paddr == 8'h24;
  // ==========================================================
  // Properties
  property p_rst_vals;
    $rose(resetn) |-> serial_tx_out == '1 && request_to_send_out_n == '1
      && terminal_ready_out_n == '1 && channel_irq_oe == '0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset state");
  property p_rts;
    mc0 |=> ##1 request_to_send_out_n[0] == !$past(pwdata[1], 2);
  endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong");
  property p_dtr;
    mc0 |=> ##1 terminal_ready_out_n[0] == !$past(pwdata[0], 2);
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr level wrong");
  property p_oe;
    mc1 |=> ##1 channel_irq_oe[1] == $past(pwdata[3], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("irq enable wrong");
  property p_op2;
    user_output_two_n == ~channel_irq_oe;
  endproperty
  a_op2: assert property (p_op2) else $error("user out wrong");
  property p_start;
    $fell(serial_tx_out[0]) |-> !serial_tx_out[0] [*8];
  endproperty
  a_start: assert property (p_start) else $error("short bit");
  property p_unmapped;
    psel && !penable && paddr[7:6] != 2'b00 |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slverr");
  property p_rd_hold;
    psel && penable |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
  c_frame: cover property ($fell(serial_tx_out[0]));
  c_err: cover property (psel && penable && pslverr);
  c_oe: cover property ($rose(channel_irq_oe[1]));
endmodule
bind umd_top umd_checker #(.NUM_CH(NUM_CH)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_tx_out(serial_tx_out),
  .request_to_send_out_n(request_to_send_out_n),
  .terminal_ready_out_n(terminal_ready_out_n),
  .user_output_two_n(user_output_two_n), .channel_irq_oe(channel_irq_oe)
);

//--- umd_peer.sv
// Far-end line model: sends and captures framed characters
`timescale 1ns/100ps
module umd_peer #(
  parameter int BIT = 16
) (
  input wire logic clk_sys,
  input wire logic tx,
  output logic rx
);
  initial rx = 1'b1;
  // Even parity, one stop; bad flips the parity bit
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx <= f[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask
  // Samples each bit in its middle, ends inside the stop bit
  task automatic catch(output logic [10:0] f, output logic ok);
    int n;
    n = 0;
    while (tx !== 1'b0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    ok = n < 5000;
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      if (i > 0) repeat (BIT) @(posedge clk_sys);
      f[i] = tx;
    end
  endtask
endmodule

//--- uart_modem_pins_reset_framing_tb.sv
// Self-checking bench for the serial channel block
`timescale 1ns/100ps
module uart_modem_pins_reset_framing_tb;
  logic clk_sys, resetn, psel, penable, pwrite, osc_out, pready, pslverr;
  logic peer_rx, ok, err_s;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] f;
  logic [1:0] tx, rts_n, dtr_n, op2_n, irq, oe, cts_n, dsr_n, cd_n, ri_n;
  wire [9:0] pins = {tx, rts_n, dtr_n, op2_n, oe};
  int num_errors = 0;
  int comparisons = 0;
  umd_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .osc_out(osc_out),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_tx_out(tx), .serial_rx_in({1'b1, peer_rx}),
    .request_to_send_out_n(rts_n), .clear_to_send_in_n(cts_n),
    .terminal_ready_out_n(dtr_n), .set_ready_in_n(dsr_n),
    .carrier_detect_in_n(cd_n), .ring_indicator_in_n(ri_n),
    .user_output_two_n(op2_n), .channel_irq_out(irq),
    .channel_irq_oe(oe));
  umd_peer u_peer (.clk_sys(clk_sys), .tx(tx[0]), .rx(peer_rx));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #600000;
    num_errors++;
    results();
  end
  task automatic results();
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // Bus transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    q = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {resetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {cts_n, dsr_n, cd_n, ri_n} = 8'hFF;
    repeat (2) @(posedge clk_sys);
    chk(pins, 10'h3FC);
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #2;
    chk(osc_out, 1'b1);
    chk(pins, 10'h3FC);
    rd(8'h04, 32'h0);
    rd(8'h1C, 32'h36);
    apb(1'b1, 8'h24, 32'h0B);
    repeat (2) @(negedge clk_sys);
    chk(pins, 10'h356);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk(pins, 10'h3FC);
    rd(8'h24, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({err_s, q}, 33'h1_0000_0000);
    cts_n <= 2'b10;
    dsr_n <= 2'b10;
    cd_n <= 2'b10;
    ri_n <= 2'b10;
    repeat (3) @(posedge clk_sys);
    rd(8'h18, 32'hF0);
    apb(1'b1, 8'h1C, 32'h1);
    apb(1'b1, 8'h08, 32'h18);
    apb(1'b1, 8'h04, 32'h02);
    apb(1'b1, 8'h0C, 32'hC0);
    cts_n <= 2'b11;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, 8'h00, 32'hA7);
    apb(1'b1, 8'h00, 32'h3C);
    apb(1'b0, 8'h14, 32'h0);
    chk(q & 32'h20, 32'h0);
    repeat (40) @(posedge clk_sys);
    chk(tx[0], 1'b1);
    cts_n <= 2'b10;
    u_peer.catch(f, ok);
    chk({ok, f}, {2'b11, ^8'hA7, 8'hA7, 1'b0});
    u_peer.catch(f, ok);
    chk({ok, f}, {2'b11, ^8'h3C, 8'h3C, 1'b0});
    u_peer.send(8'h5A, 1'b0);
    u_peer.send(8'hC3, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk(rts_n[0], 1'b1);
    u_peer.send(8'h99, 1'b0);
    repeat (4) @(posedge clk_sys);
    rd(8'h14, 32'h63);
    rd(8'h00, 32'h5A);
    rd(8'h00, 32'hC3);
    apb(1'b1, 8'h14, 32'h0E);
    chk(rts_n[0], 1'b0);
    rd(8'h14, 32'h60);
    u_peer.send(8'h11, 1'b1);
    repeat (4) @(posedge clk_sys);
    rd(8'h14, 32'h65);
    apb(1'b1, 8'h10, 32'h01);
    apb(1'b1, 8'h04, 32'h0A);
    repeat (2) @(negedge clk_sys);
    chk({irq[0], oe[0], op2_n[0]}, 3'b110);
    results();
  end
endmodule
